/* battery_thermal_monitor_mux_tb.sv */
`timescale 1ns/1ps
module battery_thermal_monitor_mux_tb;
    import btm_pkg::*;
    localparam logic [3:0] CH_T = 4'h8;
    localparam logic [3:0] CH_B = 4'h9;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic valid = 1'b1;
    logic other_fault_i = 1'b0;
    logic [2:0] charger_state_i = 3'h0;
    logic [2:0] temp = ZONE_NORMAL;
    logic hot, warm, cool, cold, mod_st, pause, tpause, rst_pulse, fc_rst, cfg_irq, t_irq, bias, buf_en;
    logic [1:0] hs, ws, cs, ds, fault;
    logic [5:0] avc, acc;
    logic [2:0] rst_st, zone;
    logic [3:0] sel;
    logic [7:0] rdata_o;
    int seed = 5;
    int errors = 0;
    int compares = 0;
    int restores = 0;

    always #4 clk_i = ~clk_i;

    // counts fault exits that pulse restore and timer reset together
    always @(posedge clk_i) begin
        if (rst_pulse === 1'b1 && fc_rst === 1'b1)
            restores++;
    end

    btm_ntc_model i_btm_ntc_model (.clk_i(clk_i), .temp_i(temp), .hot_cmp_o(hot), .warm_cmp_o(warm),
        .cool_cmp_o(cool), .cold_cmp_o(cold));

    btm_monitor #(.CH_THERM(CH_T), .CH_BIAS(CH_B)) i_btm_monitor (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .charger_input_valid_i(valid),
        .hot_cmp_i(hot), .warm_cmp_i(warm), .cool_cmp_i(cool), .cold_cmp_i(cold), .charger_state_i(charger_state_i),
        .other_fault_i(other_fault_i), .hot_trip_select_o(hs), .warm_trip_select_o(ws), .cool_trip_select_o(cs),
        .cold_trip_select_o(ds), .active_voltage_code_o(avc), .active_current_code_o(acc),
        .modified_state_o(mod_st), .charge_pause_o(pause), .active_fault_o(fault), .timer_pause_o(tpause),
        .restore_o(rst_pulse), .restore_state_o(rst_st), .fc_topoff_timer_reset_o(fc_rst),
        .temperature_zone_status_o(zone), .sys_config_error_irq_o(cfg_irq), .temperature_change_irq_o(t_irq),
        .thermistor_bias_pin_o(bias), .analog_channel_select_o(sel), .analog_monitor_out_en_o(buf_en));

    // ****************************************
    // checking and bus tasks
    // ****************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        we_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
        @(posedge clk_i);
        re_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1;
        check(rdata_o, e, m);
    endtask

    function automatic logic [5:0] exp_cv(input logic [5:0] s, input logic [5:0] c);
        logic [15:0] smv;
        smv = SYS_BASE_MV + s * SYS_STEP_MV;
        while (c != 6'h00 && smv < CV_BASE_MV + c * CV_STEP_MV + SYS_MARGIN_MV)
            c = c - 6'h01;
        return c;
    endfunction

    function automatic logic [7:0] exp_status(input logic [2:0] z);
        return {3'h0, z == ZONE_WARM || z == ZONE_COOL, z == ZONE_HOT || z == ZONE_COLD, z};
    endfunction

    task automatic report_and_stop;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #(8 * 30000);
        errors++;
        report_and_stop;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [7:0] rst_tab [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08,
            8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
        logic [2:0] zl [8] = '{ZONE_NORMAL, ZONE_WARM, ZONE_HOT, ZONE_COOL,
            ZONE_COLD, ZONE_WARM, ZONE_NORMAL, ZONE_COLD};
        logic [5:0] s, c;
        logic [7:0] cv, cc, mcv, mcc, v;
        logic [2:0] saved;
        logic mz, fz, pf;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wr(8'h2C, 8'hFF);
        for (int i = 0; i < 12; i++)
            rdc(8'(i * 4), rst_tab[i], "reset value");
        wr(ADDR_MASK, 8'h03);
        for (int i = 0; i < 6; i++) begin
            s = (i == 0) ? 6'h08 : 6'($random(seed));
            c = (i == 0) ? 6'h3F : 6'($random(seed));
            wr(ADDR_CV, 8'h00);
            wr(ADDR_SYS_V, {2'h0, s});
            wr(ADDR_CV, {2'h0, c});
            repeat (70) @(posedge clk_i);
            rdc(ADDR_CV, {2'h0, exp_cv(s, c)}, "cv code");
            check({7'h0, cfg_irq}, {7'h0, exp_cv(s, c) != c}, "cfg irq");
            wr(ADDR_FLAGS, 8'h03);
        end
        cv = 8'($random(seed)) & 8'h1F;
        cc = 8'($random(seed)) & 8'h3F;
        mcv = 8'($random(seed)) & 8'h3F;
        mcc = 8'($random(seed)) & 8'h3F;
        wr(ADDR_SYS_V, 8'h3F);
        wr(ADDR_CV, cv);
        wr(ADDR_CC, cc);
        wr(ADDR_MOD_CV, mcv);
        wr(ADDR_MOD_CC, mcc);
        wr(ADDR_FLAGS, 8'h03);
        wr(ADDR_CTRL, 8'h01);
        pf = 1'b0;
        for (int i = 0; i < 8; i++) begin
            temp <= zl[i];
            other_fault_i <= i[0];
            charger_state_i <= 3'($random(seed));
            repeat (6) @(posedge clk_i);
            mz = zl[i] == ZONE_WARM || zl[i] == ZONE_COOL;
            fz = zl[i] == ZONE_HOT || zl[i] == ZONE_COLD;
            if (fz && !pf)
                saved = charger_state_i;
            if (!fz && pf)
                check({5'h0, rst_st}, {5'h0, saved}, "restore state");
            pf = fz;
            rdc(ADDR_STATUS, exp_status(zl[i]), "zone status");
            check({3'h0, mod_st, pause, zone}, exp_status(zl[i]), "zone pins");
            check({7'h0, t_irq}, 8'h01, "temp irq");
            wr(ADDR_FLAGS, 8'h02);
            if (fz)
                check({6'h0, fault}, {6'h0, FAULT_TEMP}, "fault prio");
            else begin
                check({6'h0, fault}, {6'h0, i[0] ? FAULT_OTHER : FAULT_NONE}, "other fault");
                check({2'h0, avc}, mz ? mcv : cv, "volt code");
                check({2'h0, acc}, mz ? mcc : cc, "curr code");
            end
        end
        check({7'h0, tpause}, 8'h01, "timer pause");
        check({7'h0, bias}, 8'h01, "bias enabled");
        wr(ADDR_CTRL, 8'h00);
        repeat (6) @(posedge clk_i);
        rdc(ADDR_STATUS, 8'h07, "disabled status");
        check({6'h0, pause, bias}, 8'h00, "disabled pause bias");
        @(posedge clk_i);
        temp <= ZONE_HOT;
        valid <= 1'b0;
        wr(ADDR_CTRL, 8'h01);
        for (int i = 0; i < 16; i++) begin
            wr(ADDR_MUX, 8'(i));
            repeat (3) @(posedge clk_i);
            check({4'h0, sel}, 8'(i), "mux select");
            check({7'h0, buf_en}, {7'h0, i != 0}, "buffer");
            check({7'h0, bias}, {7'h0, 4'(i) == CH_T || 4'(i) == CH_B}, "mux bias");
            rdc(ADDR_STATUS, exp_status(ZONE_HOT), "status under mux");
        end
        wr(ADDR_MUX, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 8'hE4 : 8'($random(seed));
            wr(ADDR_TRIP, v);
            #1;
            check({ds, cs, ws, hs}, v, "trip fields");
        end
        check(8'(restores), 8'h03, "restore pulses");
        report_and_stop;
    end
endmodule

/* btm_monitor.sv */
`timescale 1ns/1ps
// Functional notes
// - Too small margin: hardware steps stored charge voltage code down until met or the code reaches zero.
// - Forced code reduction raises the system configuration error interrupt.
// - Thermistor enabled: zone continuously evaluated from threshold comparators.
// - Between cool and warm: normal codes, no modified state.
// - Warm-hot or cold-cool band: modified codes used, modified state entered.
// - Modified voltage and current are independent six-bit codes.
// - Beyond hot or cold: charging paused, temperature fault state entered.
// - Three-bit zone status; interrupt flag set on every change.
// - Thermistor disabled removes every automatic temperature reaction.
// - Each trip point chosen independently by its own two-bit field.
// - Bias on while charger input valid and thermistor enabled.
// - Bias on while mux routes thermistor or bias node out.
// - Channel select never disturbs comparators or temperature response.
// - Four-bit select chooses the signal routed to monitor output.
// - Output buffer on only for nonzero select, else high-impedance.
// - Battery current channels selectable in any mode, any time.
// - Temperature fault wins over other faults; exit restores prior state.
// - Fault pauses timers; exit resumes prequal, restarts fast-charge and top-off.
module btm_monitor
    import btm_pkg::*;
#(
    parameter int CODE_W = 6,
    parameter int STATE_W = 3,
    parameter logic [3:0] CH_THERM = 4'h8,
    parameter logic [3:0] CH_BIAS = 4'h9
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [7:0] rdata_o,
    input wire logic charger_input_valid_i,
    input wire logic hot_cmp_i,
    input wire logic warm_cmp_i,
    input wire logic cool_cmp_i,
    input wire logic cold_cmp_i,
    input wire logic [STATE_W-1:0] charger_state_i,
    input wire logic other_fault_i,
    output logic [1:0] hot_trip_select_o,
    output logic [1:0] warm_trip_select_o,
    output logic [1:0] cool_trip_select_o,
    output logic [1:0] cold_trip_select_o,
    output logic [CODE_W-1:0] active_voltage_code_o,
    output logic [CODE_W-1:0] active_current_code_o,
    output logic modified_state_o,
    output logic charge_pause_o,
    output logic [1:0] active_fault_o,
    output logic timer_pause_o,
    output logic restore_o,
    output logic [STATE_W-1:0] restore_state_o,
    output logic fc_topoff_timer_reset_o,
    output logic [2:0] temperature_zone_status_o,
    output logic sys_config_error_irq_o,
    output logic temperature_change_irq_o,
    output logic thermistor_bias_pin_o,
    output logic [3:0] analog_channel_select_o,
    output logic analog_monitor_out_en_o
);

    // ****************************************
    // elaboration checks
    // ****************************************
    if (CODE_W != 6) begin : g_bad_code
        $error("btm_monitor: CODE_W must be 6");
    end
    if (STATE_W < 1 || STATE_W > 8) begin : g_bad_state
        $error("btm_monitor: STATE_W out of range");
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] code_to_mv(input logic [5:0] code, input logic [15:0] base,
                                               input logic [15:0] step);
        logic [15:0] prod;
        prod = 16'({10'h000, code} * step);
        code_to_mv = 16'(base + prod);
    endfunction

    function automatic logic [7:0] pad6(input logic [5:0] v);
        pad6 = {2'h0, v};
    endfunction

    // ****************************************
    // register state
    // ****************************************
    logic therm_en_q, therm_en_d;
    logic [5:0] cv_q, cv_d;
    logic [5:0] cc_q, cc_d;
    logic [5:0] mod_cv_q, mod_cv_d;
    logic [5:0] mod_cc_q, mod_cc_d;
    logic [5:0] sys_v_q, sys_v_d;
    logic [7:0] trip_q, trip_d;
    logic [3:0] mux_q, mux_d;
    logic [1:0] flags_q, flags_d;
    logic [1:0] mask_q, mask_d;
    logic [7:0] rdata_q, rdata_d;

    // ****************************************
    // comparator synchronisers
    // ****************************************
    logic [3:0] cmp_meta_q, cmp_sync_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmp_meta_q <= 4'h0;
            cmp_sync_q <= 4'h0;
        end else begin
            cmp_meta_q <= {hot_cmp_i, warm_cmp_i, cool_cmp_i, cold_cmp_i};
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // ****************************************
    // zone decode
    // ****************************************
    logic [2:0] zone;
    always_comb begin
        if (!therm_en_q) begin
            zone = ZONE_OFF;
        end else if (cmp_sync_q[3]) begin
            zone = ZONE_HOT;
        end else if (cmp_sync_q[0]) begin
            zone = ZONE_COLD;
        end else if (cmp_sync_q[2]) begin
            zone = ZONE_WARM;
        end else if (cmp_sync_q[1]) begin
            zone = ZONE_COOL;
        end else begin
            zone = ZONE_NORMAL;
        end
    end

    logic in_fault_zone, in_mod_zone;
    assign in_fault_zone = (zone == ZONE_HOT) || (zone == ZONE_COLD);
    assign in_mod_zone = (zone == ZONE_WARM) || (zone == ZONE_COOL);

    // ****************************************
    // voltage margin check
    // ****************************************
    logic [15:0] cv_mv, sys_mv, need_mv;
    logic margin_bad;
    assign cv_mv = code_to_mv(cv_q, CV_BASE_MV, CV_STEP_MV);
    assign sys_mv = code_to_mv(sys_v_q, SYS_BASE_MV, SYS_STEP_MV);
    assign need_mv = 16'(cv_mv + SYS_MARGIN_MV);
    assign margin_bad = (sys_mv < need_mv) && (cv_q != 6'h00);

    // ****************************************
    // register file next values
    // ****************************************
    logic [2:0] zone_q, zone_d;
    logic zone_changed;
    assign zone_changed = (zone != zone_q);

    always_comb begin
        therm_en_d = therm_en_q;
        cv_d = cv_q;
        cc_d = cc_q;
        mod_cv_d = mod_cv_q;
        mod_cc_d = mod_cc_q;
        sys_v_d = sys_v_q;
        trip_d = trip_q;
        mux_d = mux_q;
        flags_d = flags_q;
        mask_d = mask_q;
        rdata_d = 8'h00;
        zone_d = zone;
        if (we_i) begin
            case (addr_i)
                ADDR_CTRL: therm_en_d = wdata_i[CTRL_THERM_EN_BIT];
                ADDR_CV: cv_d = wdata_i[5:0];
                ADDR_CC: cc_d = wdata_i[5:0];
                ADDR_MOD_CV: mod_cv_d = wdata_i[5:0];
                ADDR_MOD_CC: mod_cc_d = wdata_i[5:0];
                ADDR_SYS_V: sys_v_d = wdata_i[5:0];
                ADDR_TRIP: trip_d = wdata_i;
                ADDR_MUX: mux_d = wdata_i[3:0];
                ADDR_FLAGS: flags_d = flags_q & ~wdata_i[1:0];
                ADDR_MASK: mask_d = wdata_i[1:0];
                default: begin
                end
            endcase
        end
        if (margin_bad && !(we_i && addr_i == ADDR_CV)) begin
            cv_d = 6'(cv_q - 6'h01);
        end
        if (margin_bad) begin
            flags_d[FLAG_SYSCFG_BIT] = 1'b1;
        end
        if (zone_changed) begin
            flags_d[FLAG_TEMP_BIT] = 1'b1;
        end
        if (re_i) begin
            case (addr_i)
                ADDR_CTRL: rdata_d = {7'h00, therm_en_q};
                ADDR_CV: rdata_d = pad6(cv_q);
                ADDR_CC: rdata_d = pad6(cc_q);
                ADDR_MOD_CV: rdata_d = pad6(mod_cv_q);
                ADDR_MOD_CC: rdata_d = pad6(mod_cc_q);
                ADDR_SYS_V: rdata_d = pad6(sys_v_q);
                ADDR_TRIP: rdata_d = trip_q;
                ADDR_MUX: rdata_d = {4'h0, mux_q};
                ADDR_STATUS: rdata_d = {3'h0, modified_state_o, charge_pause_o, zone_q};
                ADDR_FLAGS: rdata_d = {6'h00, flags_q};
                ADDR_MASK: rdata_d = {6'h00, mask_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            therm_en_q <= RST_CTRL[CTRL_THERM_EN_BIT];
            cv_q <= RST_CV;
            cc_q <= RST_CC;
            mod_cv_q <= RST_CV;
            mod_cc_q <= RST_CC;
            sys_v_q <= RST_SYS_V;
            trip_q <= RST_TRIP;
            mux_q <= RST_MUX;
            flags_q <= 2'h0;
            mask_q <= RST_MASK;
            rdata_q <= 8'h00;
            zone_q <= ZONE_OFF;
        end else begin
            therm_en_q <= therm_en_d;
            cv_q <= cv_d;
            cc_q <= cc_d;
            mod_cv_q <= mod_cv_d;
            mod_cc_q <= mod_cc_d;
            sys_v_q <= sys_v_d;
            trip_q <= trip_d;
            mux_q <= mux_d;
            flags_q <= flags_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
            zone_q <= zone_d;
        end
    end

    // ****************************************
    // temperature fault tracking
    // ****************************************
    btm_state_t state_q, state_d;
    logic [STATE_W-1:0] saved_q, saved_d;
    logic restore_q, restore_d;
    logic tmr_rst_q, tmr_rst_d;

    always_comb begin
        state_d = state_q;
        saved_d = saved_q;
        restore_d = 1'b0;
        tmr_rst_d = 1'b0;
        case (state_q)
            BTM_RUN: begin
                if (in_fault_zone) begin
                    state_d = BTM_FAULT;
                    saved_d = charger_state_i;
                end
            end
            BTM_FAULT: begin
                if (!in_fault_zone) begin
                    state_d = BTM_RUN;
                    restore_d = 1'b1;
                    tmr_rst_d = 1'b1;
                end
            end
            default: state_d = BTM_RUN;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= BTM_RUN;
            saved_q <= '0;
            restore_q <= 1'b0;
            tmr_rst_q <= 1'b0;
        end else begin
            state_q <= state_d;
            saved_q <= saved_d;
            restore_q <= restore_d;
            tmr_rst_q <= tmr_rst_d;
        end
    end

    // ****************************************
    // charge parameter selection
    // ****************************************
    logic [5:0] act_v_q, act_v_d;
    logic [5:0] act_i_q, act_i_d;
    logic mod_q, mod_d;
    logic [1:0] fault_q, fault_d;
    logic bias_q, bias_d;

    always_comb begin
        act_v_d = in_mod_zone ? mod_cv_q : cv_q;
        act_i_d = in_mod_zone ? mod_cc_q : cc_q;
        mod_d = in_mod_zone;
        if (in_fault_zone) begin
            fault_d = FAULT_TEMP;
        end else if (other_fault_i) begin
            fault_d = FAULT_OTHER;
        end else begin
            fault_d = FAULT_NONE;
        end
        // bias depends on mux only through routing, never on comparators
        bias_d = (charger_input_valid_i && therm_en_q)
            || (mux_q == CH_THERM) || (mux_q == CH_BIAS);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            act_v_q <= RST_CV;
            act_i_q <= RST_CC;
            mod_q <= 1'b0;
            fault_q <= FAULT_NONE;
            bias_q <= 1'b0;
        end else begin
            act_v_q <= act_v_d;
            act_i_q <= act_i_d;
            mod_q <= mod_d;
            fault_q <= fault_d;
            bias_q <= bias_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign rdata_o = rdata_q;
    assign hot_trip_select_o = trip_q[TRIP_HOT_LSB +: 2];
    assign warm_trip_select_o = trip_q[TRIP_WARM_LSB +: 2];
    assign cool_trip_select_o = trip_q[TRIP_COOL_LSB +: 2];
    assign cold_trip_select_o = trip_q[TRIP_COLD_LSB +: 2];
    assign active_voltage_code_o = act_v_q;
    assign active_current_code_o = act_i_q;
    assign modified_state_o = mod_q;
    assign charge_pause_o = (state_q == BTM_FAULT);
    assign timer_pause_o = (state_q == BTM_FAULT);
    assign active_fault_o = fault_q;
    assign restore_o = restore_q;
    assign restore_state_o = saved_q;
    assign fc_topoff_timer_reset_o = tmr_rst_q;
    assign temperature_zone_status_o = zone_q;
    assign sys_config_error_irq_o = flags_q[FLAG_SYSCFG_BIT] & mask_q[FLAG_SYSCFG_BIT];
    assign temperature_change_irq_o = flags_q[FLAG_TEMP_BIT] & mask_q[FLAG_TEMP_BIT];
    assign thermistor_bias_pin_o = bias_q;
    assign analog_channel_select_o = mux_q;
    assign analog_monitor_out_en_o = (mux_q != MUX_OFF);

endmodule

/* btm_monitor_chk_monitor.sv */
`timescale 1ns/1ps
// ****************************************
// checker on the monitor block ports
// ****************************************
module btm_monitor_chk
    import btm_pkg::*;
#(
    parameter logic [3:0] CH_THERM = 4'h8,
    parameter logic [3:0] CH_BIAS = 4'h9
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic charge_pause_o,
    input wire logic timer_pause_o,
    input wire logic [1:0] active_fault_o,
    input wire logic restore_o,
    input wire logic fc_topoff_timer_reset_o,
    input wire logic modified_state_o,
    input wire logic [2:0] temperature_zone_status_o,
    input wire logic [3:0] analog_channel_select_o,
    input wire logic analog_monitor_out_en_o,
    input wire logic thermistor_bias_pin_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_buf_en;
        analog_monitor_out_en_o == (analog_channel_select_o != MUX_OFF);
    endproperty
    a_buf_en: assert property (p_buf_en) else $error("buffer enable wrong");
    property p_bias_mux;
        analog_channel_select_o == CH_THERM || analog_channel_select_o == CH_BIAS |=> thermistor_bias_pin_o;
    endproperty
    a_bias_mux: assert property (p_bias_mux) else $error("bias off for routed node");
    property p_pause_zone;
        charge_pause_o == (temperature_zone_status_o == ZONE_HOT || temperature_zone_status_o == ZONE_COLD);
    endproperty
    a_pause_zone: assert property (p_pause_zone) else $error("pause not tied to zone");
    property p_fault_prio;
        $rose(charge_pause_o) |-> ##[0:1] active_fault_o == FAULT_TEMP;
    endproperty
    a_fault_prio: assert property (p_fault_prio) else $error("temperature fault not first");
    property p_restore;
        $fell(charge_pause_o) |-> ##[0:1] (restore_o && fc_topoff_timer_reset_o);
    endproperty
    a_restore: assert property (p_restore) else $error("no restore on fault exit");
    property p_timer;
        timer_pause_o == (temperature_zone_status_o == ZONE_HOT || temperature_zone_status_o == ZONE_COLD);
    endproperty
    a_timer: assert property (p_timer) else $error("timers not paused");
    property p_normal;
        (temperature_zone_status_o == ZONE_NORMAL) [*2] |-> !modified_state_o && !charge_pause_o;
    endproperty
    a_normal: assert property (p_normal) else $error("modified in normal zone");
    property p_mod;
        (temperature_zone_status_o == ZONE_WARM || temperature_zone_status_o == ZONE_COOL) [*2] |-> modified_state_o;
    endproperty
    a_mod: assert property (p_mod) else $error("modified state missing");
    property p_off;
        (temperature_zone_status_o == ZONE_OFF) [*2] |-> !modified_state_o && !charge_pause_o;
    endproperty
    a_off: assert property (p_off) else $error("reaction while disabled");
endmodule

bind btm_monitor btm_monitor_chk #(.CH_THERM(CH_THERM), .CH_BIAS(CH_BIAS)) i_btm_monitor_chk (.clk_i(clk_i),
    .rst_i(rst_i), .charge_pause_o(charge_pause_o), .timer_pause_o(timer_pause_o), .active_fault_o(active_fault_o),
    .restore_o(restore_o), .fc_topoff_timer_reset_o(fc_topoff_timer_reset_o), .modified_state_o(modified_state_o),
    .temperature_zone_status_o(temperature_zone_status_o), .analog_channel_select_o(analog_channel_select_o),
    .analog_monitor_out_en_o(analog_monitor_out_en_o), .thermistor_bias_pin_o(thermistor_bias_pin_o));

/* btm_ntc_model.sv */
`timescale 1ns/1ps
// ****************************************
// thermistor comparator bank model
// ****************************************
module btm_ntc_model
    import btm_pkg::*;
(
    input wire logic clk_i,
    input wire logic [2:0] temp_i,
    output logic hot_cmp_o,
    output logic warm_cmp_o,
    output logic cool_cmp_o,
    output logic cold_cmp_o
);
    // comparators update on the same clk_i edge the block samples on, one cycle after temp_i changes
    always_ff @(posedge clk_i) begin
        hot_cmp_o <= temp_i == ZONE_HOT;
        warm_cmp_o <= temp_i >= ZONE_WARM;
        cool_cmp_o <= temp_i <= ZONE_COOL;
        cold_cmp_o <= temp_i == ZONE_COLD;
    end
endmodule

/* btm_pkg.sv */
package btm_pkg;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CV = 8'h04;
    localparam logic [7:0] ADDR_CC = 8'h08;
    localparam logic [7:0] ADDR_MOD_CV = 8'h0C;
    localparam logic [7:0] ADDR_MOD_CC = 8'h10;
    localparam logic [7:0] ADDR_SYS_V = 8'h14;
    localparam logic [7:0] ADDR_TRIP = 8'h18;
    localparam logic [7:0] ADDR_MUX = 8'h1C;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_FLAGS = 8'h24;
    localparam logic [7:0] ADDR_MASK = 8'h28;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTRL_THERM_EN_BIT = 0;
    localparam int TRIP_HOT_LSB = 0;
    localparam int TRIP_WARM_LSB = 2;
    localparam int TRIP_COOL_LSB = 4;
    localparam int TRIP_COLD_LSB = 6;
    localparam int FLAG_SYSCFG_BIT = 0;
    localparam int FLAG_TEMP_BIT = 1;
    localparam int STATUS_FAULT_BIT = 3;
    localparam int STATUS_MOD_BIT = 4;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [5:0] RST_CV = 6'h00;
    localparam logic [5:0] RST_CC = 6'h00;
    localparam logic [5:0] RST_SYS_V = 6'h08;
    localparam logic [7:0] RST_TRIP = 8'h00;
    localparam logic [3:0] RST_MUX = 4'h0;
    localparam logic [1:0] RST_MASK = 2'h0;

    // ****************************************
    // voltage scaling, millivolts
    // ****************************************
    localparam logic [15:0] CV_BASE_MV = 16'h0E10;
    localparam logic [15:0] CV_STEP_MV = 16'h0019;
    localparam logic [15:0] SYS_BASE_MV = 16'h0E10;
    localparam logic [15:0] SYS_STEP_MV = 16'h0019;
    localparam logic [15:0] SYS_MARGIN_MV = 16'h00C8;

    // ****************************************
    // zone codes and faults
    // ****************************************
    localparam logic [2:0] ZONE_COLD = 3'h0;
    localparam logic [2:0] ZONE_COOL = 3'h1;
    localparam logic [2:0] ZONE_NORMAL = 3'h2;
    localparam logic [2:0] ZONE_WARM = 3'h3;
    localparam logic [2:0] ZONE_HOT = 3'h4;
    localparam logic [2:0] ZONE_OFF = 3'h7;
    localparam logic [1:0] FAULT_NONE = 2'h0;
    localparam logic [1:0] FAULT_OTHER = 2'h1;
    localparam logic [1:0] FAULT_TEMP = 2'h2;
    localparam logic [3:0] MUX_OFF = 4'h0;

    typedef enum logic [0:0] {
        BTM_RUN = 1'b0,
        BTM_FAULT = 1'b1
    } btm_state_t;
endpackage
